/* File: sasb_attr_mem.sv */
// Attribute table: thirty entries of three words, byte-writable, two read ports.
`timescale 1ns/1ns
`default_nettype none
module sasb_attr_mem
    import sasb_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    sasb_mem_if.mem mif
);
    sasb_mem_t st_ff;
    sasb_mem_t nxt_st;
    logic [6:0] base;

    // ****************************************************************
    // Write path
    // ****************************************************************
    // Byte lanes are merged so software may update a single field.
    always_comb begin
        nxt_st = st_ff;
        if (mif.wr_en) begin
            for (int b = 0; b < 4; b++) begin
                if (mif.wr_sel[b]) begin
                    nxt_st.w[mif.wr_word][b*8 +: 8] = mif.wr_data[b*8 +: 8];
                end
            end
        end
    end

    // Table clears to inactive entries so an early read is well defined.
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_ff <= SASB_MEM_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************************
    // Read ports
    // ****************************************************************
    // The stream port sees all three words of one entry at once.
    assign base = 7'(mif.st_ent * 2'd3);
    assign mif.bus_data = st_ff.w[mif.bus_word];
    assign mif.st_words = {st_ff.w[7'(base + 7'd2)], st_ff.w[7'(base + 7'd1)], st_ff.w[base]};
endmodule
`default_nettype wire

/* File: sasb_host_model.sv */
// Host-side consumer model that takes the attribute sector byte stream.
`timescale 1ns/1ns
`default_nettype none
module sasb_host_model (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic slow_i,
    input wire logic clr_i,
    input wire logic out_valid_i,
    input wire logic [7:0] out_data_i,
    input wire logic out_last_i,
    output logic out_ready_o
);
    // ****************
    // Byte capture
    // ****************
    logic [7:0] cap [512];
    int cnt = 0;
    int last_at = -1;
    int seed = 32'h1d3;
    // A slow host stalls at random, so each byte must stand until it is taken.
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i || clr_i) begin
            out_ready_o <= 1'b0;
            cnt <= 0;
            last_at <= -1;
        end else begin
            out_ready_o <= slow_i ? 1'($random(seed)) : 1'b1;
            if (out_valid_i && out_ready_o) begin
                if (cnt < 512) cap[cnt] <= out_data_i;
                if (out_last_i) last_at <= cnt;
                cnt <= cnt + 1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: sasb_mem_if.sv */
// Interface joining the sector engine to the attribute table.
`timescale 1ns/1ns
`default_nettype none
interface sasb_mem_if;
    logic wr_en;
    logic [3:0] wr_sel;
    logic [6:0] wr_word;
    logic [31:0] wr_data;
    logic [6:0] bus_word;
    logic [31:0] bus_data;
    logic [4:0] st_ent;
    logic [95:0] st_words;

    modport mem (
        input wr_en, wr_sel, wr_word, wr_data, bus_word, st_ent,
        output bus_data, st_words
    );
    modport ctl (
        output wr_en, wr_sel, wr_word, wr_data, bus_word, st_ent,
        input bus_data, st_words
    );
endinterface
`default_nettype wire

/* File: sasb_pkg.sv */
// Package with sector layout, register map, codes and state types of the attribute sector builder.
package sasb_pkg;

    // ****************************************************************
    // Sector layout
    // ****************************************************************
    localparam int SASB_N_ATTR = 30;
    localparam int SASB_N_WORDS = 90;
    localparam logic [8:0] B_REV_LO = 9'h000;
    localparam logic [8:0] B_REV_HI = 9'h001;
    localparam logic [8:0] B_ENT_FIRST = 9'h002;
    localparam logic [8:0] B_ENT_LAST = 9'h169;
    localparam logic [8:0] B_OFFST = 9'h16a;
    localparam logic [8:0] B_STST = 9'h16b;
    localparam logic [8:0] B_TIME_LO = 9'h16c;
    localparam logic [8:0] B_TIME_HI = 9'h16d;
    localparam logic [8:0] B_SEGPTR = 9'h16e;
    localparam logic [8:0] B_OFFCAP = 9'h16f;
    localparam logic [8:0] B_SCAP_LO = 9'h170;
    localparam logic [8:0] B_SCAP_HI = 9'h171;
    localparam logic [8:0] B_ERRCAP = 9'h172;
    localparam logic [8:0] B_FAILPT = 9'h173;
    localparam logic [8:0] B_POLL_S = 9'h174;
    localparam logic [8:0] B_POLL_X = 9'h175;
    localparam logic [8:0] B_CSUM = 9'h1ff;

    // Byte offsets inside one 12-byte entry.
    localparam logic [3:0] E_ID = 4'h0;
    localparam logic [3:0] E_FLAG_LO = 4'h1;
    localparam logic [3:0] E_CUR = 4'h3;
    localparam logic [3:0] E_WORST = 4'h4;
    localparam logic [3:0] E_RAW0 = 4'h5;
    localparam logic [3:0] E_RAW5 = 4'ha;
    localparam logic [3:0] E_LAST = 4'hb;

    // ****************************************************************
    // Fixed values and limits
    // ****************************************************************
    localparam logic [15:0] REV_VAL = 16'h0005;
    localparam logic [7:0] SEGPTR_VAL = 8'h01;
    localparam logic [15:0] SCAP_VAL = 16'h0003;
    localparam logic [7:0] ERRCAP_VAL = 8'h01;
    localparam logic [7:0] CUR_MIN = 8'h01;
    localparam logic [7:0] CUR_MAX = 8'hfd;
    localparam logic [7:0] WORST_MAX = 8'hfe;
    localparam logic [3:0] PCT_MAX = 4'h9;
    localparam logic [3:0] ST_FATAL = 4'h3;
    localparam logic [3:0] ST_RUN = 4'hf;
    localparam logic [6:0] OFF_NEVER = 7'h00;
    localparam logic [6:0] OFF_DONE = 7'h02;
    localparam logic [6:0] OFF_FATAL = 7'h06;
    localparam logic [6:0] OFF_ILLEGAL = 7'h01;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [9:0] R_CTRL = 10'h000;
    localparam logic [9:0] R_OFFST = 10'h004;
    localparam logic [9:0] R_STST = 10'h008;
    localparam logic [9:0] R_TIME = 10'h00c;
    localparam logic [9:0] R_OFFCAP = 10'h010;
    localparam logic [9:0] R_FAILPT = 10'h014;
    localparam logic [9:0] R_POLL = 10'h018;
    localparam logic [9:0] R_STATUS = 10'h01c;
    localparam logic [4:0] R_ENT_PAGE = 5'h10;
    localparam logic [1:0] R_ENT_WMAX = 2'h2;

    typedef enum logic [0:0] {
        SASB_IDLE = 1'b0,
        SASB_SEND = 1'b1
    } sasb_phase_t;

    typedef struct packed {
        sasb_phase_t phase;
        logic [8:0] idx;
        logic [4:0] ent;
        logic [3:0] off;
        logic [7:0] sum;
        logic [7:0] data;
        logic valid;
        logic last;
        logic [7:0] csum;
        logic ack;
        logic [31:0] rdat;
        logic auto_en;
        logic [6:0] off_code;
        logic [3:0] st_pct;
        logic [3:0] st_code;
        logic [15:0] off_time;
        logic [7:0] off_cap;
        logic [7:0] fail_pt;
        logic [7:0] poll_s;
        logic [7:0] poll_x;
    } sasb_state_t;

    localparam sasb_state_t SASB_RST = '0;

    typedef struct packed {
        logic [SASB_N_WORDS-1:0][31:0] w;
    } sasb_mem_t;

    localparam sasb_mem_t SASB_MEM_RST = '0;

endpackage

/* File: sasb_top.sv */
// Attribute value sector builder: register slave and byte stream engine.
//
// Contract
// - The sector is always delivered whole, 512 bytes, per read request.
// - Bytes 0-1 carry revision 0005h, shared with the threshold sector.
// - Bytes 2-361 hold thirty 12-byte entries, byte 11 of each is zero.
// - Flag bit 0 set means pre-failure attribute, clear means advisory.
// - Flag bit 1 set means online updates, clear means offline-only updates.
// - Flag bits 2-5 mark attribute classes; bits 6-15 are zero.
// - Current value stays 01h-FDh, worst value stays 01h-FEh.
// - Bytes 5-10 hold raw data; all ones means saturated counter.
// - Nonzero identifier marks an active entry; inactive entries read zero.
// - Offline status bit 7 shows whether automatic collection is enabled.
// - Offline status bits 0-6 use only codes 0, 2, 3, 4, 5, 6.
// - Self-test remaining tenths in bits 0-3, only 0 to 9.
// - Self-test status bits 4-7 use codes 0-7 or 15.
// - Bytes 364-365 give offline collection time in seconds.
// - Next-segment counter always reads 01h.
// - Byte 367 holds the offline capability flags.
// - Capability word reads 0003h.
// - Error logging byte reads 01h.
// - Byte 371 holds the self-test failure check point.
// - Bytes 372 and 373 hold short and extended polling minutes.
// - Byte 511 makes the modulo-256 sector sum zero.
// - Multi-byte fields go least significant byte first.
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module sasb_top
    import sasb_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rd_req_i,
    input wire logic out_ready_i,
    output logic out_valid_o,
    output logic [7:0] out_data_o,
    output logic out_last_o,
    output logic busy_o
);
    sasb_state_t st_ff;
    sasb_state_t nxt_st;
    sasb_mem_if mif();
    logic req;
    logic ent_hit;
    logic start;
    logic adv;
    logic [8:0] ni;
    logic [4:0] nent;
    logic [3:0] noff;
    logic [7:0] nsum;
    logic [7:0] nbyte;
    logic [31:0] w0;
    logic [47:0] raw;

    sasb_attr_mem u_mem (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .mif(mif)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Only documented offline codes are kept; anything else reads as never started.
    function automatic logic [6:0] off_legal(input logic [6:0] c);
        logic [6:0] r;
        r = OFF_NEVER;
        if (c >= OFF_DONE && c <= OFF_FATAL) begin
            r = c;
        end
        return r;
    endfunction

    // Unknown self-test codes fold into the fatal-or-unknown code.
    function automatic logic [3:0] st_legal(input logic [3:0] c);
        logic [3:0] r;
        r = ST_FATAL;
        if (c <= 4'h7 || c == ST_RUN) begin
            r = c;
        end
        return r;
    endfunction

    function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] hi);
        logic [7:0] r;
        r = v;
        if (v < CUR_MIN) begin
            r = CUR_MIN;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    // ****************************************************************
    // Table access
    // ****************************************************************
    // Entry page: entry n word k at 0x200 + 16n + 4k, k below three.
    assign req = wb_cyc_i && wb_stb_i && !st_ff.ack;
    assign ent_hit = wb_adr_i[9:5] >= R_ENT_PAGE && wb_adr_i[8:4] < 5'(SASB_N_ATTR)
        && wb_adr_i[3:2] <= R_ENT_WMAX;
    assign mif.bus_word = 7'(wb_adr_i[8:4] * 2'd3) + 7'(wb_adr_i[3:2]);
    assign mif.wr_word = mif.bus_word;
    assign mif.wr_en = req && wb_we_i && ent_hit;
    assign mif.wr_sel = wb_sel_i;
    assign mif.wr_data = wb_dat_i;
    assign mif.st_ent = nent;
    assign w0 = mif.st_words[31:0];
    assign raw = mif.st_words[79:32];

    // ****************************************************************
    // Stream sequencing
    // ****************************************************************
    // Index, entry and offset of the byte that will be presented next.
    always_comb begin
        start = st_ff.phase == SASB_IDLE && rd_req_i;
        adv = st_ff.phase == SASB_SEND && st_ff.valid && out_ready_i;
        ni = start ? B_REV_LO : 9'(st_ff.idx + 9'd1);
        nsum = start ? 8'h00 : 8'(st_ff.sum + st_ff.data);
        nent = st_ff.ent;
        noff = 4'(st_ff.off + 4'd1);
        if (ni == B_ENT_FIRST) begin
            nent = 5'h00;
            noff = E_ID;
        end else if (st_ff.off == E_LAST) begin
            nent = 5'(st_ff.ent + 5'd1);
            noff = E_ID;
        end
    end

    // ****************************************************************
    // Sector byte map
    // ****************************************************************
    // Unlisted bytes, vendor bytes and reserved ranges fall to zero.
    always_comb begin
        nbyte = 8'h00;
        if (ni >= B_ENT_FIRST && ni <= B_ENT_LAST) begin
            if (w0[7:0] != 8'h00) begin
                unique case (noff)
                    E_ID: nbyte = w0[7:0];
                    E_FLAG_LO: nbyte = {2'b00, w0[13:8]};
                    E_CUR: nbyte = clamp(w0[23:16], CUR_MAX);
                    E_WORST: nbyte = clamp(w0[31:24], WORST_MAX);
                    default: begin
                        if (noff >= E_RAW0 && noff <= E_RAW5) begin
                            nbyte = raw[{3'(noff - E_RAW0), 3'b000} +: 8];
                        end
                    end
                endcase
            end
        end else begin
            unique case (ni)
                B_REV_LO: nbyte = REV_VAL[7:0];
                B_REV_HI: nbyte = REV_VAL[15:8];
                B_OFFST: nbyte = {st_ff.auto_en, st_ff.off_code};
                B_STST: nbyte = {st_ff.st_code, st_ff.st_pct};
                B_TIME_LO: nbyte = st_ff.off_time[7:0];
                B_TIME_HI: nbyte = st_ff.off_time[15:8];
                B_SEGPTR: nbyte = SEGPTR_VAL;
                B_OFFCAP: nbyte = st_ff.off_cap;
                B_SCAP_LO: nbyte = SCAP_VAL[7:0];
                B_SCAP_HI: nbyte = SCAP_VAL[15:8];
                B_ERRCAP: nbyte = ERRCAP_VAL;
                B_FAILPT: nbyte = st_ff.fail_pt;
                B_POLL_S: nbyte = st_ff.poll_s;
                B_POLL_X: nbyte = st_ff.poll_x;
                B_CSUM: nbyte = 8'(8'h00 - nsum);
                default: nbyte = 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Requests during a transfer are ignored; the host always gets a whole sector.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = req;
        if (start) begin
            nxt_st.phase = SASB_SEND;
            nxt_st.idx = ni;
            nxt_st.sum = nsum;
            nxt_st.data = nbyte;
            nxt_st.valid = 1'b1;
            nxt_st.last = 1'b0;
        end else if (adv) begin
            if (st_ff.last) begin
                nxt_st.phase = SASB_IDLE;
                nxt_st.valid = 1'b0;
                nxt_st.last = 1'b0;
                nxt_st.csum = st_ff.data;
            end else begin
                nxt_st.idx = ni;
                nxt_st.ent = nent;
                nxt_st.off = noff;
                nxt_st.sum = nsum;
                nxt_st.data = nbyte;
                nxt_st.last = ni == B_CSUM;
            end
        end
        // Register writes are sanitised so the sector never shows illegal codes.
        if (req && wb_we_i) begin
            unique case (wb_adr_i)
                R_CTRL: if (wb_sel_i[0]) nxt_st.auto_en = wb_dat_i[0];
                R_OFFST: if (wb_sel_i[0]) nxt_st.off_code = off_legal(wb_dat_i[6:0]);
                R_STST: begin
                    if (wb_sel_i[0]) begin
                        nxt_st.st_pct = wb_dat_i[3:0] > PCT_MAX ? PCT_MAX : wb_dat_i[3:0];
                        nxt_st.st_code = st_legal(wb_dat_i[7:4]);
                    end
                end
                R_TIME: begin
                    if (wb_sel_i[0]) nxt_st.off_time[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1]) nxt_st.off_time[15:8] = wb_dat_i[15:8];
                end
                R_OFFCAP: if (wb_sel_i[0]) nxt_st.off_cap = wb_dat_i[7:0];
                R_FAILPT: if (wb_sel_i[0]) nxt_st.fail_pt = wb_dat_i[7:0];
                R_POLL: begin
                    if (wb_sel_i[0]) nxt_st.poll_s = wb_dat_i[7:0];
                    if (wb_sel_i[1]) nxt_st.poll_x = wb_dat_i[15:8];
                end
                default: ;
            endcase
        end
        // Read data is registered with the ack; unmapped words read zero.
        if (req) begin
            unique case (wb_adr_i)
                R_CTRL: nxt_st.rdat = {31'h0, st_ff.auto_en};
                R_OFFST: nxt_st.rdat = {24'h0, st_ff.auto_en, st_ff.off_code};
                R_STST: nxt_st.rdat = {24'h0, st_ff.st_code, st_ff.st_pct};
                R_TIME: nxt_st.rdat = {16'h0, st_ff.off_time};
                R_OFFCAP: nxt_st.rdat = {24'h0, st_ff.off_cap};
                R_FAILPT: nxt_st.rdat = {24'h0, st_ff.fail_pt};
                R_POLL: nxt_st.rdat = {16'h0, st_ff.poll_x, st_ff.poll_s};
                R_STATUS: nxt_st.rdat = {16'h0, st_ff.csum, 7'h0, st_ff.phase};
                default: nxt_st.rdat = ent_hit ? mif.bus_data : 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_ff <= SASB_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Every output is a field of the state register.
    assign wb_ack_o = st_ff.ack;
    assign wb_dat_o = st_ff.rdat;
    assign out_valid_o = st_ff.valid;
    assign out_data_o = st_ff.data;
    assign out_last_o = st_ff.last;
    assign busy_o = st_ff.phase;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    logic shown;
    logic in_ent;
    assign shown = st_ff.valid;
    assign in_ent = st_ff.idx >= B_ENT_FIRST && st_ff.idx <= B_ENT_LAST;

    a_full_sector: assert property (
        out_last_o |-> st_ff.idx == B_CSUM) else $error("last byte not at 511");
    a_rev_word: assert property (
        shown && st_ff.idx == B_REV_LO |-> out_data_o == 8'h05)
        else $error("revision byte wrong");
    a_entry_pad: assert property (
        shown && in_ent && st_ff.off == E_LAST |-> out_data_o == 8'h00)
        else $error("entry pad byte nonzero");
    a_flag_rsvd: assert property (
        shown && in_ent && st_ff.off == 4'h2 |-> out_data_o == 8'h00)
        else $error("reserved flag byte nonzero");
    a_cur_range: assert property (
        shown && in_ent && st_ff.off == E_CUR && out_data_o != 8'h00
        |-> out_data_o >= 8'h01 && out_data_o <= 8'hfd) else $error("current out of range");
    a_auto_bit: assert property (
        shown && st_ff.idx == B_OFFST |-> out_data_o[7] == st_ff.auto_en)
        else $error("auto offline bit wrong");
    a_pct_valid: assert property (
        shown && st_ff.idx == B_STST |-> out_data_o[3:0] <= 4'h9)
        else $error("self-test percent invalid");
    a_seg_ptr: assert property (
        shown && st_ff.idx == B_SEGPTR |-> out_data_o == 8'h01) else $error("segment not 01h");
    a_smart_cap: assert property (
        shown && st_ff.idx == B_SCAP_LO && out_ready_i
        |=> out_data_o == 8'h00 && st_ff.idx == B_SCAP_HI) else $error("capability wrong");
    a_sum_zero: assert property (
        out_last_o && out_ready_i |-> 8'(st_ff.sum + out_data_o) == 8'h00)
        else $error("sector checksum not zero");
    a_stall_hold: assert property (
        out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o)
        && $stable(st_ff.idx)) else $error("byte changed under stall");
    a_start_seq: assert property (
        !busy_o && rd_req_i |=> out_valid_o && st_ff.idx == 9'h000 ##1 st_ff.idx <= 9'h001)
        else $error("sector did not start at byte 0");
    a_wb_ack: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not single cycle");

    c_sector_done: cover property (out_last_o && out_ready_i);
    c_stall: cover property (out_valid_o && !out_ready_i ##1 out_ready_i);
    c_ent_write: cover property (mif.wr_en ##1 wb_ack_o);
    c_req_busy: cover property (busy_o && rd_req_i);
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the attribute sector builder.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import sasb_pkg::*;
    // ****************
    // Stimulus and model state
    // ****************
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, rd_req = 1'b0, slow = 1'b0, clr = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [31:0] dat = 32'h0, q;
    logic [3:0] sel = 4'hf;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, ready, out_valid_o, out_last_o, busy_o;
    logic [7:0] out_data_o;
    int error_cnt = 0, n_checks = 0, seed = 32'h5942;
    logic [7:0] m_id [30] = '{default: 0}, m_flg [30], m_cur [30], m_wst [30], exp_s [512];
    logic [47:0] m_raw [30];
    logic m_auto = 1'b0;
    logic [6:0] m_off = 7'h00;
    logic [3:0] m_pct = 4'h0, m_st = 4'h0;
    logic [15:0] m_time = 16'h0;
    logic [7:0] m_cap = 8'h0, m_fail = 8'h0, m_ps = 8'h0, m_px = 8'h0;

    always #20 clk = ~clk;

    sasb_top dut_u (.sys_clk_i(clk), .nrst_i(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .rd_req_i(rd_req), .out_ready_i(ready),
        .out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_last_o(out_last_o),
        .busy_o(busy_o));
    sasb_host_model host_u (.sys_clk_i(clk), .nrst_i(nrst), .slow_i(slow), .clr_i(clr),
        .out_valid_i(out_valid_o), .out_data_i(out_data_o), .out_last_i(out_last_o),
        .out_ready_o(ready));

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    // One classic cycle; entered just after an edge, it holds everything until ack.
    task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        do begin @(posedge clk); n++; end while (wb_ack_o !== 1'b1 && n < 100);
        if (n >= 100) error_cnt++;
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    // Expected sector worked out from the model state, checksum last.
    task automatic build_exp;
        int e, o, s;
        s = 0;
        for (int k = 0; k < 511; k++) begin
            exp_s[k] = 8'h00;
            e = (k - 2) / 12;
            o = (k - 2) % 12;
            if (k >= 2 && k < 362 && m_id[e] != 0) begin
                if (o == 0) exp_s[k] = m_id[e];
                if (o == 1) exp_s[k] = m_flg[e] & 8'h3f;
                if (o == 3) exp_s[k] = m_cur[e] < 1 ? 8'h01 : m_cur[e] > 253 ? 8'hfd : m_cur[e];
                if (o == 4) exp_s[k] = m_wst[e] < 1 ? 8'h01 : m_wst[e] > 254 ? 8'hfe : m_wst[e];
                if (o >= 5 && o <= 10) exp_s[k] = m_raw[e][(o-5)*8+:8];
            end
            case (k)
                0: exp_s[k] = 8'h05;
                362: exp_s[k] = {m_auto, (m_off == 1 || m_off > 6) ? 7'h00 : m_off};
                363: exp_s[k] = {(m_st > 7 && m_st < 15) ? 4'h3 : m_st, m_pct > 9 ? 4'h9 : m_pct};
                364: exp_s[k] = m_time[7:0];
                365: exp_s[k] = m_time[15:8];
                366, 370: exp_s[k] = 8'h01;
                367: exp_s[k] = m_cap;
                368: exp_s[k] = 8'h03;
                371: exp_s[k] = m_fail;
                372: exp_s[k] = m_ps;
                373: exp_s[k] = m_px;
                default: ;
            endcase
            s += exp_s[k];
        end
        exp_s[511] = 8'(0 - s);
    endtask

    // A second request in mid-sector must be dropped, not restart the stream.
    task automatic run_sector;
        int n;
        build_exp();
        rd_req <= 1'b1;
        clr <= 1'b1;
        @(posedge clk);
        rd_req <= 1'b0;
        clr <= 1'b0;
        repeat (20) @(posedge clk);
        rd_req <= 1'b1;
        @(posedge clk);
        rd_req <= 1'b0;
        n = 0;
        while (busy_o !== 1'b0 && n < 3000) begin @(posedge clk); n++; end
        repeat (3) @(posedge clk);
        chk("bytes", 512, host_u.cnt);
        chk("last", 511, host_u.last_at);
        chk("valid", 0, {31'h0, out_valid_o});
        for (int k = 0; k < 512; k++)
            chk("byte", {24'h0, exp_s[k]}, {24'h0, host_u.cap[k]});
        wb(1'b1, R_STATUS, 32'hffffffff);
        wb(1'b0, R_STATUS, 32'h0);
        chk("csum", {24'h0, exp_s[511]}, {24'h0, q[15:8]});
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #(40 * 60000);
        error_cnt++;
        print_verdict();
    end

    // ****************
    // Main sequence
    // ****************
    initial begin
        logic [31:0] r;
        logic [9:0] a;
        int e;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        run_sector();
        for (int i = 0; i < 16; i++) begin
            for (int j = 0; j < 2; j++) begin
                e = j ? 29 - i : i;
                r = $random(seed);
                m_id[e] = r[1:0] == 0 ? 8'h00 : r[15:8];
                r = $random(seed);
                {m_wst[e], m_cur[e], m_flg[e]} = r[23:0];
                if (i < 2) {m_id[e], m_cur[e], m_wst[e]} = i ? 24'hb1fe00 : 24'h0900ff;
                m_raw[e] = i % 4 == 3 ? '1 : 48'({$random(seed), $random(seed)});
                a = 10'h200 + 10'(e * 16);
                wb(1'b1, a, {m_wst[e], m_cur[e], m_flg[e], m_id[e]});
                wb(1'b1, a + 10'h4, m_raw[e][31:0]);
                wb(1'b1, a + 10'h8, {16'h0, m_raw[e][47:32]});
                wb(1'b0, a + 10'h4, 32'h0);
                chk("raw", m_raw[e][31:0], q);
                wb(1'b0, a + 10'hc, 32'h0);
                chk("unmapped", 32'h0, q);
            end
            m_auto = i[0];
            m_off = 7'(i % 8);
            {m_st, m_pct} = {4'(15 - i), 4'(i)};
            r = $random(seed);
            {m_fail, m_cap, m_time} = r;
            r = $random(seed);
            {m_px, m_ps} = r[15:0];
            wb(1'b1, R_CTRL, {31'h0, m_auto});
            wb(1'b1, R_OFFST, {25'h0, m_off});
            wb(1'b1, R_STST, {24'h0, m_st, m_pct});
            wb(1'b1, R_TIME, {16'h0, m_time});
            wb(1'b1, R_OFFCAP, {24'h0, m_cap});
            wb(1'b1, R_FAILPT, {24'h0, m_fail});
            wb(1'b1, R_POLL, {16'h0, m_px, m_ps});
            slow <= i[1];
            run_sector();
        end
        print_verdict();
    end
endmodule
`default_nettype wire
